// ==== pmc_power_mode_controller.v ====
`timescale 1ns/1ps
`include "pmc_regs.vh"

module pmc_power_mode_controller #(
   parameter [31:0] WAKE_CYCLES = `PMC_WAKE_CYCLES
)
(
   input wire clk,
   input wire reset_n,
   input wire inputAboveUvlo,
   input wire inputAboveOvp,
   input wire inputAboveSleepMargin,
   input wire inputAboveFloor,
   input wire batteryAboveUvlo,
   input wire batteryAboveMaxUvlo,
   input wire batteryOvercurrent,
   input wire wake_button_n,
   input wire low_power_request_n,
   input wire ship_entry_request,
   input wire shipRequestClear,
   input wire busIrqBusy,
   input wire output_rail_enable,
   input wire chargeEnable,
   output reg [1:0] operatingMode,
   output reg alwaysOnRailEnable,
   output reg batterySwitchOn,
   output reg inputPathOn,
   output reg chargeAllow,
   output reg adcContinuous,
   output reg busEnable,
   output reg oscEnable,
   output reg outputRailOn,
   output reg shipPending
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   wire [12:0] syncIn;
   pmc_sync #(.WIDTH(13), .RESET_VALUE(13'h0_060)) uSync (
      .clk(clk),
      .reset_n(reset_n),
      .asyncIn({chargeEnable,
         inputAboveUvlo, inputAboveOvp, inputAboveSleepMargin, inputAboveFloor,
         batteryAboveUvlo, batteryAboveMaxUvlo, wake_button_n, low_power_request_n,
         batteryOvercurrent, ship_entry_request, shipRequestClear, busIrqBusy}),
      .syncOut(syncIn)
   );
   wire chgEn = syncIn[12];
   wire vinOk = syncIn[11];
   wire vinOvp = syncIn[10];
   wire vinMargin = syncIn[9];
   wire vinFloor = syncIn[8];
   wire batOk = syncIn[7];
   wire batHigh = syncIn[6];
   wire buttonN = syncIn[5];
   wire lpN = syncIn[4];
   wire battery_overcurrent_trip = syncIn[3];
   wire shipReq = syncIn[2];
   wire shipClr = syncIn[1];
   wire busBusy = syncIn[0];

   // ----------------------------------------
   // Mode state machine
   // ----------------------------------------
   localparam [2:0] ST_BATINS = 3'd0;
   localparam [2:0] ST_SHIP = 3'd1;
   localparam [2:0] ST_WAKE = 3'd2;
   localparam [2:0] ST_ACTBAT = 3'd3;
   localparam [2:0] ST_LOWPWR = 3'd4;
   localparam [2:0] ST_ADAPT = 3'd5;

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [31:0] wakeCnt_r;
   reg [31:0] wakeCnt_nxt;
   reg wakeDone_r;
   reg wakeDone_nxt;
   reg pending_r;
   reg pending_nxt;
   reg ocpTrip_r;
   reg railHold_r;
   reg [1:0] settleCnt_r;
   // Terminal count of the long press timer
   wire wakeExpired = (wakeCnt_r >= WAKE_CYCLES - 32'h0000_0001);
   // Ship entry needs input gone and button released; charge enable not consulted
   wire shipGo = pending_r && !vinOk && buttonN;
   // Low power entry waits for bus and interrupt traffic to finish
   wire lpGo = !lpN && !vinOk && buttonN && !busBusy && !vinOvp;
   // Overvoltage input with the pin low is served from the battery
   wire adaptOk = vinOk && !(vinOvp && !lpN);

   always @*
   begin
      state_nxt = state_r;
      wakeCnt_nxt = wakeCnt_r;
      wakeDone_nxt = wakeDone_r;
      // Clear only while input valid; a new request wins; watchdog has no path here
      pending_nxt = pending_r;
      if (shipClr && vinOk)
         pending_nxt = 1'b0;
      if (shipReq)
         pending_nxt = 1'b1;
      case (state_r)
         ST_BATINS:
         begin
            // Decide only once the synchronisers carry real pin levels
            if (settleCnt_r != 2'h2)
               state_nxt = ST_BATINS;
            else if (vinOk)
               state_nxt = adaptOk ? ST_ADAPT : ST_ACTBAT;
            else if (buttonN)
               state_nxt = ST_SHIP;
            else
            begin
               state_nxt = ST_WAKE;
               wakeCnt_nxt = 32'h0000_0000;
               wakeDone_nxt = 1'b0;
            end
         end
         ST_SHIP:
         begin
            // Requests are discarded while latched off
            pending_nxt = 1'b0;
            if (vinOk)
               state_nxt = adaptOk ? ST_ADAPT : ST_ACTBAT;
            else if (!buttonN && batHigh)
            begin
               state_nxt = ST_WAKE;
               wakeCnt_nxt = 32'h0000_0000;
               wakeDone_nxt = 1'b0;
            end
         end
         ST_WAKE:
         begin
            // Release before the long press time falls back to ship
            if (vinOk)
               state_nxt = adaptOk ? ST_ADAPT : ST_ACTBAT;
            else if (!buttonN)
            begin
               if (wakeExpired)
                  wakeDone_nxt = 1'b1;
               else
                  wakeCnt_nxt = wakeCnt_r + 32'h0000_0001;
            end
            else if (wakeDone_r && batOk)
               state_nxt = ST_ACTBAT;
            else
               state_nxt = ST_SHIP;
         end
         ST_ACTBAT:
         begin
            // Low battery drops to ship only when no input is present
            if (adaptOk)
               state_nxt = ST_ADAPT;
            else if (shipGo || (!batOk && !vinOk))
               state_nxt = ST_SHIP;
            else if (lpGo)
               state_nxt = ST_LOWPWR;
         end
         ST_LOWPWR:
         begin
            // Any wake source leaves low power before ship is considered
            if (vinOk || lpN || vinOvp || !buttonN)
               state_nxt = adaptOk ? ST_ADAPT : ST_ACTBAT;
            else if (shipGo || !batOk)
               state_nxt = ST_SHIP;
         end
         ST_ADAPT:
         begin
            // Overvoltage input with the pin low falls back to battery
            if (!adaptOk)
            begin
               if (shipGo || (!batOk && !vinOk))
                  state_nxt = ST_SHIP;
               else
                  state_nxt = ST_ACTBAT;
            end
         end
         default:
            state_nxt = ST_SHIP;
      endcase
   end

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r <= ST_BATINS;
         wakeCnt_r <= 32'h0000_0000;
         wakeDone_r <= 1'b0;
         pending_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         wakeCnt_r <= wakeCnt_nxt;
         wakeDone_r <= wakeDone_nxt;
         pending_r <= pending_nxt;
      end
   end

   // ----------------------------------------
   // Insertion settle counter
   // ----------------------------------------
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         settleCnt_r <= 2'h0;
      else if (state_r == ST_BATINS && settleCnt_r != 2'h2)
         settleCnt_r <= settleCnt_r + 2'h1;
   end

   // ----------------------------------------
   // Battery switch protection
   // ----------------------------------------
   // Overcurrent latches the switch open until ship mode or a valid input clears it
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         ocpTrip_r <= 1'b0;
      else if (state_r == ST_SHIP || vinOk)
         ocpTrip_r <= 1'b0;
      else if (battery_overcurrent_trip)
         ocpTrip_r <= 1'b1;
   end

   // Output rail enable sampled while awake, frozen in low power
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         railHold_r <= 1'b0;
      else if (state_nxt == ST_ACTBAT || state_nxt == ST_ADAPT)
         railHold_r <= output_rail_enable;
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   wire inAdapt = (state_nxt == ST_ADAPT);
   wire inLp = (state_nxt == ST_LOWPWR);
   wire inAct = (state_nxt == ST_ACTBAT);
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         operatingMode <= `PMC_RST_MODE;
         alwaysOnRailEnable <= 1'b0;
         batterySwitchOn <= 1'b0;
         inputPathOn <= 1'b0;
         chargeAllow <= 1'b0;
         adcContinuous <= 1'b0;
         busEnable <= 1'b0;
         oscEnable <= 1'b0;
         outputRailOn <= 1'b0;
         shipPending <= 1'b0;
      end
      else
      begin
         // One mode only; wake timing and insertion checks count as ship
         if (inAdapt)
            operatingMode <= `PMC_MODE_ADAPT;
         else if (inLp)
            operatingMode <= `PMC_MODE_LOWPWR;
         else if (inAct)
            operatingMode <= `PMC_MODE_ACTBAT;
         else
            operatingMode <= `PMC_MODE_SHIP;
         // Always-on rail off in ship, on during insertion check and wake timing
         alwaysOnRailEnable <= !(state_nxt == ST_SHIP);
         batterySwitchOn <= (inAct || inLp) && batOk && !ocpTrip_r && !battery_overcurrent_trip;
         inputPathOn <= inAdapt && vinMargin && !vinOvp;
         chargeAllow <= inAdapt && vinFloor && !vinOvp && chgEn;
         adcContinuous <= inAdapt;
         busEnable <= inAdapt || inAct;
         oscEnable <= inAdapt || inAct || (state_nxt == ST_WAKE);
         outputRailOn <= (inAdapt || inAct) ? output_rail_enable : (inLp && railHold_r);
         shipPending <= pending_nxt;
      end
   end
endmodule

// ==== pmc_regs.vh ====
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// Operating mode encodings
`define PMC_MODE_SHIP 2'h0
`define PMC_MODE_LOWPWR 2'h1
`define PMC_MODE_ACTBAT 2'h2
`define PMC_MODE_ADAPT 2'h3

// Long wake press time in milliseconds, and the clock rate in kHz
// Product kept inside 32 bits
`define PMC_WAKE_TIME_MS 32'd2000
`define PMC_CLK_KHZ 32'd25000
`define PMC_WAKE_CYCLES (`PMC_WAKE_TIME_MS * `PMC_CLK_KHZ)

// Reset values
`define PMC_RST_MODE `PMC_MODE_SHIP

`endif

// ==== pmc_sync.v ====
`timescale 1ns/1ps
module pmc_sync #(
   parameter WIDTH = 8,
   parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
)
(
   input wire clk,
   input wire reset_n,
   input wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] stage1_r;
   reg [WIDTH-1:0] stage2_r;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : gBit
         always @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               stage1_r[i] <= RESET_VALUE[i];
               stage2_r[i] <= RESET_VALUE[i];
            end
            else
            begin
               stage1_r[i] <= asyncIn[i];
               stage2_r[i] <= stage1_r[i];
            end
         end
      end
   endgenerate
   assign syncOut = stage2_r;
endmodule

// ==== pmc_mode_monitor.sv ====
`timescale 1ns/1ps
`include "pmc_regs.vh"
module pmc_mode_monitor (
   input wire clk,
   input wire reset_n,
   input wire inputAboveUvlo,
   input wire inputAboveOvp,
   input wire low_power_request_n,
   input wire wake_button_n,
   input wire batteryOvercurrent,
   input wire [1:0] operatingMode,
   input wire alwaysOnRailEnable,
   input wire batterySwitchOn,
   input wire inputPathOn,
   input wire adcContinuous,
   input wire busEnable,
   input wire oscEnable,
   input wire outputRailOn
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire inShip = operatingMode == `PMC_MODE_SHIP;
   wire inLow = operatingMode == `PMC_MODE_LOWPWR;
   ship_all_off_a: assert property (
      inShip |-> !batterySwitchOn && !inputPathOn && !adcContinuous && !busEnable)
      else $error("ship mode left a function on");
   lowpwr_idle_a: assert property (
      inLow |-> !busEnable && !oscEnable && !adcContinuous && alwaysOnRailEnable)
      else $error("low power mode state of bus, clocks or rail wrong");
   adapt_adc_a: assert property (
      operatingMode == `PMC_MODE_ADAPT |-> adcContinuous)
      else $error("adapter mode without continuous conversion");
   rail_hold_a: assert property (
      inLow && $past(inLow) |-> $stable(outputRailOn))
      else $error("output rail changed in low power");
   lp_exit_a: assert property (
      low_power_request_n [*6] |-> !inLow)
      else $error("low power held with request released");
   input_wake_a: assert property (
      inputAboveUvlo [*8] |-> !inShip)
      else $error("ship mode held with valid input");
   btn_active_a: assert property (
      inLow && !wake_button_n && !low_power_request_n |-> ##[1:5] !inLow)
      else $error("button press did not leave low power");
   ocp_trip_a: assert property (
      $rose(batteryOvercurrent) |-> ##[1:5] !batterySwitchOn)
      else $error("overcurrent did not open battery switch");
   ovp_path_a: assert property (
      inputAboveOvp [*6] |-> !inputPathOn)
      else $error("input path on above overvoltage");
   cover property (operatingMode == `PMC_MODE_ACTBAT);
   cover property (inLow);
   cover property (operatingMode == `PMC_MODE_ADAPT && inputPathOn);
endmodule
bind pmc_power_mode_controller pmc_mode_monitor mon (.clk, .reset_n, .inputAboveUvlo,
   .inputAboveOvp, .low_power_request_n, .wake_button_n, .batteryOvercurrent,
   .operatingMode, .alwaysOnRailEnable, .batterySwitchOn, .inputPathOn,
   .adcContinuous, .busEnable, .oscEnable, .outputRailOn);

// ==== pmc_host_model.sv ====
`timescale 1ns/1ps
module pmc_host_model (
   input wire clk,
   input wire inputValid,
   output reg wake_button_n = 1'b1,
   output reg low_power_request_n = 1'b1,
   output reg ship_entry_request = 1'b0,
   output reg shipRequestClear = 1'b0,
   output reg busIrqBusy = 1'b0
);
   task press(input integer n);
      @(negedge clk) wake_button_n = 1'b0;
      repeat (n) @(negedge clk);
      wake_button_n = 1'b1;
   endtask
   task requestShip;
      @(negedge clk) ship_entry_request = 1'b1;
      @(negedge clk) ship_entry_request = 1'b0;
   endtask
   // Clear is only issued while the supply is valid
   task clearShip;
      @(negedge clk) shipRequestClear = inputValid;
      @(negedge clk) shipRequestClear = 1'b0;
   endtask
endmodule

// ==== pmc_power_mode_controller_bench.sv ====
`timescale 1ns/1ps
`include "pmc_regs.vh"
`define CHK(n, e, g) begin nTests++; if ((g) !== (e)) begin errCount++; \
   $display("ERROR %s exp %0h got %0h", n, e, g); end end
module pmc_power_mode_controller_bench;
   reg clk = 1'b0;
   reg reset_n = 1'b0;
   reg inputAboveUvlo, inputAboveOvp, inputAboveSleepMargin, inputAboveFloor;
   reg batteryAboveUvlo, batteryAboveMaxUvlo, batteryOvercurrent;
   reg output_rail_enable, chargeEnable, rail;
   wire [1:0] operatingMode;
   wire alwaysOnRailEnable, batterySwitchOn, inputPathOn, chargeAllow, adcContinuous;
   wire busEnable, oscEnable, outputRailOn, shipPending;
   wire wake_button_n, low_power_request_n, ship_entry_request, shipRequestClear, busIrqBusy;
   integer errCount = 0;
   integer nTests = 0;
   integer cycles = 0;
   integer i;
   pmc_power_mode_controller #(.WAKE_CYCLES(32'd20)) pmc_power_mode_controller_inst (
      .clk, .reset_n, .inputAboveUvlo, .inputAboveOvp, .inputAboveSleepMargin,
      .inputAboveFloor, .batteryAboveUvlo, .batteryAboveMaxUvlo, .batteryOvercurrent,
      .wake_button_n, .low_power_request_n, .ship_entry_request, .shipRequestClear,
      .busIrqBusy, .output_rail_enable, .chargeEnable, .operatingMode,
      .alwaysOnRailEnable, .batterySwitchOn, .inputPathOn, .chargeAllow, .adcContinuous,
      .busEnable, .oscEnable, .outputRailOn, .shipPending);
   pmc_host_model host (.clk, .inputValid(inputAboveUvlo), .wake_button_n,
      .low_power_request_n, .ship_entry_request, .shipRequestClear, .busIrqBusy);
   initial
   begin
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         errCount++;
         giveVerdict;
      end
   end
   task giveVerdict;
      $display("checks %0d mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task settle;
      repeat (8) @(negedge clk);
   endtask
   task chkMode(input [1:0] e);
      `CHK("mode", e, operatingMode)
   endtask
   initial
   begin
      {inputAboveUvlo, inputAboveOvp, inputAboveSleepMargin, inputAboveFloor,
       batteryAboveUvlo, batteryAboveMaxUvlo, batteryOvercurrent,
       output_rail_enable, chargeEnable} = 9'h018;
      void'($urandom(32'h6897_8e17));
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      settle;
      chkMode(`PMC_MODE_SHIP);
      `CHK("aonRail", 1'b0, alwaysOnRailEnable)
      $display("test insertion done");
      // Low battery and short press both leave ship mode alone
      for (i = 0; i < 2; i++)
      begin
         batteryAboveMaxUvlo = i[0];
         host.press(i ? 10 : 30);
         settle;
         chkMode(`PMC_MODE_SHIP);
      end
      host.press(30);
      settle;
      chkMode(`PMC_MODE_ACTBAT);
      `CHK("batSw", 1'b1, batterySwitchOn)
      $display("test wake done");
      output_rail_enable = $urandom;
      rail = output_rail_enable;
      host.busIrqBusy = 1'b1;
      host.low_power_request_n = 1'b0;
      settle;
      chkMode(`PMC_MODE_ACTBAT);
      host.busIrqBusy = 1'b0;
      settle;
      chkMode(`PMC_MODE_LOWPWR);
      output_rail_enable = ~rail;
      settle;
      `CHK("outRail", rail, outputRailOn)
      host.wake_button_n = 1'b0;
      settle;
      chkMode(`PMC_MODE_ACTBAT);
      `CHK("bus", 1'b1, busEnable)
      host.wake_button_n = 1'b1;
      settle;
      chkMode(`PMC_MODE_LOWPWR);
      host.low_power_request_n = 1'b1;
      settle;
      chkMode(`PMC_MODE_ACTBAT);
      host.low_power_request_n = 1'b0;
      settle;
      chkMode(`PMC_MODE_LOWPWR);
      {inputAboveUvlo, inputAboveOvp} = 2'h3;
      settle;
      chkMode(`PMC_MODE_ACTBAT);
      `CHK("inPath", 1'b0, inputPathOn)
      {inputAboveUvlo, inputAboveOvp} = 2'h0;
      host.low_power_request_n = 1'b1;
      settle;
      chkMode(`PMC_MODE_ACTBAT);
      batteryOvercurrent = 1'b1;
      settle;
      `CHK("batSw", 1'b0, batterySwitchOn)
      batteryOvercurrent = 1'b0;
      $display("test battery modes done");
      {inputAboveUvlo, inputAboveSleepMargin} = 2'h3;
      for (i = 0; i < 4; i++)
      begin
         chargeEnable = $urandom;
         inputAboveFloor = $urandom;
         settle;
         chkMode(`PMC_MODE_ADAPT);
         `CHK("adc", 1'b1, adcContinuous)
         `CHK("inPath", 1'b1, inputPathOn)
         `CHK("chg", chargeEnable & inputAboveFloor, chargeAllow)
      end
      $display("test adapter done");
      host.requestShip;
      settle;
      `CHK("pend", 1'b1, shipPending)
      chkMode(`PMC_MODE_ADAPT);
      host.clearShip;
      settle;
      `CHK("pend", 1'b0, shipPending)
      host.requestShip;
      host.wake_button_n = 1'b0;
      inputAboveUvlo = 1'b0;
      settle;
      chkMode(`PMC_MODE_ACTBAT);
      host.wake_button_n = 1'b1;
      settle;
      chkMode(`PMC_MODE_SHIP);
      inputAboveUvlo = 1'b1;
      settle;
      chkMode(`PMC_MODE_ADAPT);
      $display("test ship done");
      // Reset with the low power pin low; host keeps the button down through power up
      inputAboveUvlo = 1'b0;
      host.low_power_request_n = 1'b0;
      host.wake_button_n = 1'b0;
      reset_n = 1'b0;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      repeat (30) @(negedge clk);
      `CHK("aonRail", 1'b1, alwaysOnRailEnable)
      host.wake_button_n = 1'b1;
      settle;
      chkMode(`PMC_MODE_LOWPWR);
      $display("test reset done");
      giveVerdict;
   end
endmodule
